// >>> rtl/dwm_monitor.sv
// Summary of operation
// - action 3: warn after 2 s without messages
// - current reaching level A threshold warns
// - current reaching level B threshold warns
// - current reaching feedback threshold warns
// - retry warning holds until restart delay or auto reset ends
// - retry needs delay or count above zero
// - terminal code 25, selection 2: warn, run
// - fwd/rev within 0.5 s: warn and stop
// - out-of-range or dependent-range setting flags error
// - duplicate terminal functions, except external fault, flag error
// - up and down must be assigned together
// - up/down with accel/decel select is error
// - both speed-search kinds assigned is error
// - two-wire with three-wire control is error
// - vf breakpoints must strictly decrease, both curves
// - pid target and feedback on same analog input errors
`timescale 1ns/1ps
`include "dwm_map.svh"
module dwm_monitor
  import dwm_pkg::*;
#(
  parameter int TICK_CYCLES = `DWM_TICK_NS / `DWM_CLK_NS
)
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        modbus_msg_rx,
  input  wire logic [15:0] current_level,
  input  wire logic        auto_reset_active,
  input  wire logic [7:0]  term_in,
  input  wire logic        fwd_run_in,
  input  wire logic        rev_run_in,
  output logic             comm_loss_warning,
  output logic             overcurrent_level_a_warning,
  output logic             overcurrent_level_b_warning,
  output logic             current_feedback_warning,
  output logic             retry_warning,
  output logic             ext_fault_in1_warning,
  output logic             ext_fault_in2_warning,
  output logic             ext_fault_in3_warning,
  output logic             ext_fault_in4_warning,
  output logic             ext_fault_in5_warning,
  output logic             ext_fault_in6_warning,
  output logic             ext_fault_in7_warning,
  output logic             ext_fault_in8_warning,
  output logic             direction_conflict_warning,
  output logic             stop_request,
  output logic             range_setting_error,
  output logic             input_assign_error,
  output logic             vf_curve_error,
  output logic             pid_source_error,
  output logic             warning_blink,
  output logic             irq
);
  // timer limits in ticks, derived from times in ms
  localparam logic [15:0] COMM_TICKS  =
    16'(`DWM_COMM_LOSS_MS * 1000000 / `DWM_TICK_NS);
  localparam logic [15:0] DIR_TICKS   =
    16'(`DWM_DIR_WIN_MS * 1000000 / `DWM_TICK_NS);
  localparam logic [15:0] BLINK_TICKS =
    16'(`DWM_BLINK_MS * 1000000 / `DWM_TICK_NS);

  // reset image of the state
  localparam dwm_state_t ST_RST = '{
    thr_a:   `DWM_RST_THR,
    thr_b:   `DWM_RST_THR,
    thr_fb:  `DWM_RST_THR,
    func_lo: `DWM_RST_FUNC,
    func_hi: `DWM_RST_FUNC,
    vf1_hi:  `DWM_RST_VF_HI,
    vf1_lo:  `DWM_RST_VF_LO,
    vf2_hi:  `DWM_RST_VF_HI,
    vf2_lo:  `DWM_RST_VF_LO,
    default: '0
  };

  dwm_state_t s_q;       // registered state
  dwm_state_t s_d;       // next state
  logic       comm_exp;  // no message for the loss time
  logic       dir_exp;   // direction window closed
  logic       rty_exp;   // restart delay elapsed
  logic       fwd_rise;  // forward run just became active
  logic       rev_rise;  // reverse run just became active
  logic       rty_rise;  // auto reset just started

  // mapped register offsets
  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = (a <= `DWM_OFS_INT_MASK) && (a[1:0] == 2'b00);
  endfunction

  // function code assigned to terminal i
  function automatic logic [7:0] fn_of(input logic [63:0] f,
                                       input int i);
    fn_of = f[i*8 +: 8];
  endfunction

  // any terminal carries the code
  function automatic logic has_fn(input logic [63:0] f,
                                  input logic [7:0] c);
    has_fn = 1'b0;
    for (int i = 0; i < 8; i++)
      if (fn_of(f, i) == c)
        has_fn = 1'b1;
  endfunction

  // two terminals share one countable function
  function automatic logic dup_fn(input logic [63:0] f);
    dup_fn = 1'b0;
    for (int i = 0; i < 8; i++)
      for (int j = i + 1; j < 8; j++)
        if (fn_of(f, i) == fn_of(f, j) &&
            fn_of(f, i) != `DWM_FN_EXT_FAULT &&
            fn_of(f, i) != `DWM_FN_UNUSED)
          dup_fn = 1'b1;
  endfunction

  // breakpoints not strictly falling
  function automatic logic vf_bad(input logic [31:0] hi,
                                  input logic [31:0] lo);
    vf_bad = !(hi[15:0] > hi[31:16] && hi[31:16] > lo[15:0] &&
               lo[15:0] > lo[31:16]);
  endfunction

  // edges of synchronised and internal levels
  assign fwd_rise = s_q.sync[8] & ~s_q.fwd_prev;
  assign rev_rise = s_q.sync[9] & ~s_q.rev_prev;
  assign rty_rise = auto_reset_active & ~s_q.retry_prev;

  // message watchdog, restarted by every message
  dwm_timer u_comm (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (s_q.tick),
    .start   (modbus_msg_rx),
    .limit   (COMM_TICKS),
    .expired (comm_exp)
  );

  // window opened by either run command edge
  dwm_timer u_dir (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (s_q.tick),
    .start   (fwd_rise | rev_rise),
    .limit   (DIR_TICKS),
    .expired (dir_exp)
  );

  // restart delay, counted in ticks
  dwm_timer u_rty (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (s_q.tick),
    .start   (rty_rise),
    .limit   (s_q.retry[15:0]),
    .expired (rty_exp)
  );

  // next state
  always_comb
  begin
    logic [63:0] fn;     // all terminal functions
    logic [17:0] w;      // fresh warnings
    logic [2:0]  act;    // loss action setting
    logic [1:0]  ext;    // external fault response
    logic        wr;     // write taken this edge
    fn  = '0;
    w   = '0;
    act = '0;
    ext = '0;
    wr  = 1'b0;
    s_d = s_q;
    fn  = {s_q.func_hi, s_q.func_lo};
    act = s_q.ctrl[`DWM_CTRL_ACT_LSB +: 3];
    ext = s_q.ctrl[`DWM_CTRL_EXT_LSB +: 2];

    // pin synchronisers
    s_d.meta       = {rev_run_in, fwd_run_in, term_in};
    s_d.sync       = s_q.meta;
    s_d.fwd_prev   = s_q.sync[8];
    s_d.rev_prev   = s_q.sync[9];
    s_d.retry_prev = auto_reset_active;

    // 1 ms tick divider
    s_d.tick = 1'b0;
    if (s_q.tick_cnt >= 32'(TICK_CYCLES - 1))
    begin
      s_d.tick_cnt = '0;
      s_d.tick     = 1'b1;
    end
    else
      s_d.tick_cnt = s_q.tick_cnt + 32'h00000001;

    // blink phase for flashing warnings
    if (s_q.tick)
    begin
      if (s_q.blink_cnt >= BLINK_TICKS - 16'h0001)
      begin
        s_d.blink_cnt = '0;
        s_d.blink     = ~s_q.blink;
      end
      else
        s_d.blink_cnt = s_q.blink_cnt + 16'h0001;
    end

    // communication loss
    w[`DWM_W_COMM] = (act == `DWM_ACT_WARN) & comm_exp;
    // current protection levels
    w[`DWM_W_OCA] = current_level >= s_q.thr_a[15:0];
    w[`DWM_W_OCB] = current_level >= s_q.thr_b[15:0];
    w[`DWM_W_FB]  = current_level >= s_q.thr_fb[15:0];

    // retry: set at start of auto reset, held till delay or auto reset ends
    w[`DWM_W_RETRY] = s_q.warn[`DWM_W_RETRY];
    if (rty_rise && (s_q.retry[15:0] != 16'h0000 ||
                     s_q.retry[23:16] != 8'h00))
      w[`DWM_W_RETRY] = 1'b1;
    else if (rty_exp || !auto_reset_active)
      w[`DWM_W_RETRY] = 1'b0;

    // external faults, run continues
    for (int i = 0; i < 8; i++)
      w[`DWM_W_EXT + i] = s_q.sync[i] &&
                          fn_of(fn, i) == `DWM_FN_EXT_FAULT &&
                          ext == `DWM_EXT_CONT;

    // both run commands inside the window
    w[`DWM_W_DIR] = s_q.warn[`DWM_W_DIR];
    if ((fwd_rise && s_q.sync[9] && (rev_rise || !dir_exp)) ||
        (rev_rise && s_q.sync[8] && (fwd_rise || !dir_exp)))
      w[`DWM_W_DIR] = 1'b1;
    else if (!(s_q.sync[8] && s_q.sync[9]))
      w[`DWM_W_DIR] = 1'b0;

    // range checks, some tied to other settings
    w[`DWM_W_RANGE] = act > `DWM_ACT_MAX ||
                      ext > `DWM_EXT_CONT ||
                      s_q.retry[23:16] > `DWM_RETRY_MAX ||
                      s_q.thr_a[15:0] > s_q.thr_b[15:0] ||
                      s_q.pid[3:0] > `DWM_PID_SRC_MAX ||
                      s_q.pid[7:4] > `DWM_PID_SRC_MAX;

    // terminal assignment conflicts
    w[`DWM_W_INPUT] =
      dup_fn(fn) ||
      (has_fn(fn, `DWM_FN_UP) != has_fn(fn, `DWM_FN_DOWN)) ||
      ((has_fn(fn, `DWM_FN_UP) || has_fn(fn, `DWM_FN_DOWN)) &&
       has_fn(fn, `DWM_FN_ACCDEC)) ||
      (has_fn(fn, `DWM_FN_SRCH_MAX) &&
       has_fn(fn, `DWM_FN_SRCH_SET)) ||
      (has_fn(fn, `DWM_FN_TWO_WIRE) &&
       has_fn(fn, `DWM_FN_THREE_WIRE));

    // vf curves of both motors
    w[`DWM_W_VF] = vf_bad(s_q.vf1_hi, s_q.vf1_lo) ||
                   vf_bad(s_q.vf2_hi, s_q.vf2_lo);

    // pid sources on one analog input
    w[`DWM_W_PID] = s_q.pid[3:0] == s_q.pid[7:4] &&
                    (s_q.pid[3:0] == `DWM_PID_AIN1 ||
                     s_q.pid[3:0] == `DWM_PID_AIN2);
    s_d.warn = w;

    // apb: answer registered in setup, write at access edge
    s_d.pready  = psel & ~penable;
    s_d.pslverr = psel & ~penable & ~addr_hit(paddr);
    wr = psel & penable & s_q.pready & pwrite;
    if (psel && !penable)
    begin
      if (paddr == `DWM_OFS_CTRL)
        s_d.prdata = s_q.ctrl;
      else if (paddr == `DWM_OFS_THR_A)
        s_d.prdata = s_q.thr_a;
      else if (paddr == `DWM_OFS_THR_B)
        s_d.prdata = s_q.thr_b;
      else if (paddr == `DWM_OFS_THR_FB)
        s_d.prdata = s_q.thr_fb;
      else if (paddr == `DWM_OFS_RETRY)
        s_d.prdata = s_q.retry;
      else if (paddr == `DWM_OFS_FUNC_LO)
        s_d.prdata = s_q.func_lo;
      else if (paddr == `DWM_OFS_FUNC_HI)
        s_d.prdata = s_q.func_hi;
      else if (paddr == `DWM_OFS_VF1_HI)
        s_d.prdata = s_q.vf1_hi;
      else if (paddr == `DWM_OFS_VF1_LO)
        s_d.prdata = s_q.vf1_lo;
      else if (paddr == `DWM_OFS_VF2_HI)
        s_d.prdata = s_q.vf2_hi;
      else if (paddr == `DWM_OFS_VF2_LO)
        s_d.prdata = s_q.vf2_lo;
      else if (paddr == `DWM_OFS_PID)
        s_d.prdata = s_q.pid;
      else if (paddr == `DWM_OFS_WARN)
        s_d.prdata = {14'h0000, s_q.warn};
      else if (paddr == `DWM_OFS_INT_STAT)
        s_d.prdata = {14'h0000, s_q.status};
      else if (paddr == `DWM_OFS_INT_MASK)
        s_d.prdata = {14'h0000, s_q.mask};
      else
        s_d.prdata = '0;
    end

    // register writes, reserved bits held at zero
    s_d.status = s_q.status;
    if (wr)
    begin
      if (paddr == `DWM_OFS_CTRL)
        s_d.ctrl = pwdata & `DWM_MSK_CTRL;
      else if (paddr == `DWM_OFS_THR_A)
        s_d.thr_a = pwdata & `DWM_MSK_HALF;
      else if (paddr == `DWM_OFS_THR_B)
        s_d.thr_b = pwdata & `DWM_MSK_HALF;
      else if (paddr == `DWM_OFS_THR_FB)
        s_d.thr_fb = pwdata & `DWM_MSK_HALF;
      else if (paddr == `DWM_OFS_RETRY)
        s_d.retry = pwdata & `DWM_MSK_RETRY;
      else if (paddr == `DWM_OFS_FUNC_LO)
        s_d.func_lo = pwdata;
      else if (paddr == `DWM_OFS_FUNC_HI)
        s_d.func_hi = pwdata;
      else if (paddr == `DWM_OFS_VF1_HI)
        s_d.vf1_hi = pwdata;
      else if (paddr == `DWM_OFS_VF1_LO)
        s_d.vf1_lo = pwdata;
      else if (paddr == `DWM_OFS_VF2_HI)
        s_d.vf2_hi = pwdata;
      else if (paddr == `DWM_OFS_VF2_LO)
        s_d.vf2_lo = pwdata;
      else if (paddr == `DWM_OFS_PID)
        s_d.pid = pwdata & `DWM_MSK_PID;
      else if (paddr == `DWM_OFS_INT_STAT)
        s_d.status = s_q.status & ~pwdata[17:0];
      else if (paddr == `DWM_OFS_INT_MASK)
        s_d.mask = pwdata[17:0];
    end

    // sticky events: a new warning wins over a clear
    s_d.status = s_d.status | (w & ~s_q.warn);
    s_d.irq    = |(s_d.status & s_d.mask);
  end

  // state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_q <= ST_RST;
    else
      s_q <= s_d;
  end

  // outputs straight from the state register
  assign prdata                      = s_q.prdata;
  assign pready                      = s_q.pready;
  assign pslverr                     = s_q.pslverr;
  assign comm_loss_warning           = s_q.warn[`DWM_W_COMM];
  assign overcurrent_level_a_warning = s_q.warn[`DWM_W_OCA];
  assign overcurrent_level_b_warning = s_q.warn[`DWM_W_OCB];
  assign current_feedback_warning    = s_q.warn[`DWM_W_FB];
  assign retry_warning               = s_q.warn[`DWM_W_RETRY];
  assign ext_fault_in1_warning       = s_q.warn[`DWM_W_EXT];
  assign ext_fault_in2_warning       = s_q.warn[`DWM_W_EXT + 1];
  assign ext_fault_in3_warning       = s_q.warn[`DWM_W_EXT + 2];
  assign ext_fault_in4_warning       = s_q.warn[`DWM_W_EXT + 3];
  assign ext_fault_in5_warning       = s_q.warn[`DWM_W_EXT + 4];
  assign ext_fault_in6_warning       = s_q.warn[`DWM_W_EXT + 5];
  assign ext_fault_in7_warning       = s_q.warn[`DWM_W_EXT + 6];
  assign ext_fault_in8_warning       = s_q.warn[`DWM_W_EXT + 7];
  assign direction_conflict_warning  = s_q.warn[`DWM_W_DIR];
  assign stop_request                = s_q.warn[`DWM_W_DIR];
  assign range_setting_error         = s_q.warn[`DWM_W_RANGE];
  assign input_assign_error          = s_q.warn[`DWM_W_INPUT];
  assign vf_curve_error              = s_q.warn[`DWM_W_VF];
  assign pid_source_error            = s_q.warn[`DWM_W_PID];
  assign warning_blink               = s_q.blink;
  assign irq                         = s_q.irq;
endmodule

// >>> pkg/dwm_map.svh
`ifndef DWM_MAP_SVH
`define DWM_MAP_SVH
// clock and time base
`define DWM_CLK_NS        10
`define DWM_TICK_NS       1000000
`define DWM_COMM_LOSS_MS  2000
`define DWM_DIR_WIN_MS    500
`define DWM_BLINK_MS      250
// register byte offsets
`define DWM_OFS_CTRL      8'h00
`define DWM_OFS_THR_A     8'h04
`define DWM_OFS_THR_B     8'h08
`define DWM_OFS_THR_FB    8'h0c
`define DWM_OFS_RETRY     8'h10
`define DWM_OFS_FUNC_LO   8'h14
`define DWM_OFS_FUNC_HI   8'h18
`define DWM_OFS_VF1_HI    8'h1c
`define DWM_OFS_VF1_LO    8'h20
`define DWM_OFS_VF2_HI    8'h24
`define DWM_OFS_VF2_LO    8'h28
`define DWM_OFS_PID       8'h2c
`define DWM_OFS_WARN      8'h30
`define DWM_OFS_INT_STAT  8'h34
`define DWM_OFS_INT_MASK  8'h38
// writable bits per register
`define DWM_MSK_CTRL      32'h00000037
`define DWM_MSK_HALF      32'h0000ffff
`define DWM_MSK_RETRY     32'h00ffffff
`define DWM_MSK_PID       32'h000000ff
// reset values
`define DWM_RST_THR       32'h0000ffff
`define DWM_RST_FUNC      32'hffffffff
`define DWM_RST_VF_HI     32'h13881770
`define DWM_RST_VF_LO     32'h00960bb8
// ctrl fields, retry and pid setting values
`define DWM_CTRL_ACT_LSB  0
`define DWM_CTRL_EXT_LSB  4
`define DWM_ACT_WARN      3'h3
`define DWM_ACT_MAX       3'h4
`define DWM_EXT_CONT      2'h2
`define DWM_RETRY_MAX     8'h0a
`define DWM_PID_SRC_MAX   4'h4
`define DWM_PID_AIN1      4'h1
`define DWM_PID_AIN2      4'h2
// terminal function codes
`define DWM_FN_UP         8'h08
`define DWM_FN_DOWN       8'h09
`define DWM_FN_ACCDEC     8'h0b
`define DWM_FN_SRCH_MAX   8'h13
`define DWM_FN_EXT_FAULT  8'h19
`define DWM_FN_SRCH_SET   8'h22
`define DWM_FN_TWO_WIRE   8'h30
`define DWM_FN_THREE_WIRE 8'h31
`define DWM_FN_UNUSED     8'hff
// warning bit positions
`define DWM_W_COMM        0
`define DWM_W_OCA         1
`define DWM_W_OCB         2
`define DWM_W_FB          3
`define DWM_W_RETRY       4
`define DWM_W_DIR         5
`define DWM_W_RANGE       6
`define DWM_W_INPUT       7
`define DWM_W_VF          8
`define DWM_W_PID         9
`define DWM_W_EXT         10
`endif

// >>> pkg/dwm_pkg.sv
package dwm_pkg;
  // state of one tick timer
  typedef struct packed {
    logic [15:0] cnt;
    logic        expired;
  } dwm_tmr_t;
  // whole state of the monitor
  typedef struct packed {
    logic [9:0]  meta;
    logic [9:0]  sync;
    logic        fwd_prev;
    logic        rev_prev;
    logic        retry_prev;
    logic [31:0] ctrl;
    logic [31:0] thr_a;
    logic [31:0] thr_b;
    logic [31:0] thr_fb;
    logic [31:0] retry;
    logic [31:0] func_lo;
    logic [31:0] func_hi;
    logic [31:0] vf1_hi;
    logic [31:0] vf1_lo;
    logic [31:0] vf2_hi;
    logic [31:0] vf2_lo;
    logic [31:0] pid;
    logic [17:0] warn;
    logic [17:0] status;
    logic [17:0] mask;
    logic        irq;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic [31:0] tick_cnt;
    logic        tick;
    logic [15:0] blink_cnt;
    logic        blink;
  } dwm_state_t;
endpackage

// >>> rtl/dwm_timer.sv
`timescale 1ns/1ps
`include "dwm_map.svh"
// counts ticks after a start pulse, flags when limit is reached
module dwm_timer
  import dwm_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        tick,
  input  wire logic        start,
  input  wire logic [15:0] limit,
  output logic             expired
);
  dwm_tmr_t t_q;  // registered state
  dwm_tmr_t t_d;  // next state

  // next state: restart wins, then count until limit
  always_comb
  begin
    t_d = t_q;
    if (start)
    begin
      t_d.cnt     = 16'h0000;
      t_d.expired = 1'b0;
    end
    else if (!t_q.expired)
    begin
      if (t_q.cnt >= limit)
        t_d.expired = 1'b1;
      else if (tick)
        t_d.cnt = t_q.cnt + 16'h0001;
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      t_q <= '0;
    else
      t_q <= t_d;
  end

  assign expired = t_q.expired;
endmodule

// >>> bench/dwm_monitor_props.sv
`timescale 1ns/1ps
// ties warning outputs to their causes at the pins
module dwm_monitor_props
#(
  parameter int TICK_CYCLES = 100000
)
(
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       modbus_msg_rx,
  input wire logic [7:0] term_in,
  input wire logic       fwd_run_in,
  input wire logic       rev_run_in,
  input wire logic       auto_reset_active,
  input wire logic       comm_loss_warning,
  input wire logic       overcurrent_level_a_warning,
  input wire logic       overcurrent_level_b_warning,
  input wire logic       range_setting_error,
  input wire logic       retry_warning,
  input wire logic       ext_fault_in1_warning,
  input wire logic       direction_conflict_warning,
  input wire logic       stop_request
);
  logic [31:0] quiet_q;  // cycles since last message
  logic [31:0] quiet_d;
  // restart count on every message
  always_comb quiet_d = modbus_msg_rx ? 32'h0 : quiet_q + 32'h1;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      quiet_q <= 32'h0;
    else
      quiet_q <= quiet_d;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  comm_early_a: assert property (
    $rose(comm_loss_warning) |-> quiet_q >= 1990 * TICK_CYCLES)
    else $error("comm warning rose too early");
  comm_clear_a: assert property (
    modbus_msg_rx |-> ##3 !comm_loss_warning)
    else $error("comm warning kept after message");
  oc_order_a: assert property (
    overcurrent_level_b_warning && !range_setting_error |-> overcurrent_level_a_warning)
    else $error("level b warning without level a");
  ext_cause_a: assert property (
    ext_fault_in1_warning |-> $past(term_in[0], 3))
    else $error("external warning without pin");
  ext_clear_a: assert property (
    $fell(term_in[0]) |-> ##3 !ext_fault_in1_warning)
    else $error("external warning kept");
  retry_cause_a: assert property (
    retry_warning |-> $past(auto_reset_active))
    else $error("retry warning without auto reset");
  dir_cause_a: assert property (
    $rose(direction_conflict_warning) |-> $past(fwd_run_in, 3) && $past(rev_run_in, 3))
    else $error("direction warning without both runs");
  dir_stop_a: assert property (
    stop_request == direction_conflict_warning)
    else $error("stop request differs from direction warning");
  comm_c: cover property ($rose(comm_loss_warning));
  dir_c: cover property ($rose(direction_conflict_warning));
  ext_c: cover property ($rose(ext_fault_in1_warning));
endmodule
bind dwm_monitor dwm_monitor_props #(.TICK_CYCLES(TICK_CYCLES)) u_props (
  .pclk, .presetn, .modbus_msg_rx, .term_in, .fwd_run_in, .rev_run_in, .auto_reset_active,
  .comm_loss_warning, .overcurrent_level_a_warning, .overcurrent_level_b_warning,
  .range_setting_error, .retry_warning, .ext_fault_in1_warning,
  .direction_conflict_warning, .stop_request);

// >>> bench/dwm_host_model.sv
`timescale 1ns/1ps
// serial host: one-cycle message pulse every period cycles, silent at zero
module dwm_host_model
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [15:0] period,
  output logic             modbus_msg_rx
);
  logic [15:0] cnt_q;  // cycles since last pulse
  // interval shorter than the loss timeout keeps the link alive
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_q         <= 16'h0000;
      modbus_msg_rx <= 1'b0;
    end
    else
    begin
      cnt_q         <= (cnt_q + 16'h0001 >= period) ? 16'h0000 : cnt_q + 16'h0001;
      modbus_msg_rx <= (period != 16'h0000) && (cnt_q + 16'h0001 >= period);
    end
  end
endmodule

// >>> bench/tb.sv
`timescale 1ns/1ps
`include "dwm_map.svh"
`define CHK(nm, exp, got) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) \
    begin \
      n_fail++; \
      $display("unexpected %s: expected %h seen %h", nm, exp, got); \
    end \
  end
module tb;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [15:0] period = 16'h03e8;  // host message spacing
  logic [15:0] current_level = 16'h0000;
  logic        auto_reset_active = 1'b0;
  logic [7:0]  term_in = 8'h00;
  logic        fwd_run_in = 1'b0;
  logic        rev_run_in = 1'b0;
  logic [31:0] prdata;
  logic        pready, pslverr, modbus_msg_rx, irq, comm_loss_warning, retry_warning;
  logic        overcurrent_level_a_warning, overcurrent_level_b_warning;
  logic        current_feedback_warning, direction_conflict_warning, stop_request;
  logic        range_setting_error, input_assign_error, vf_curve_error, pid_source_error;
  logic        ext_fault_in1_warning, ext_fault_in2_warning, ext_fault_in3_warning;
  logic        ext_fault_in4_warning, ext_fault_in5_warning, ext_fault_in6_warning;
  logic        ext_fault_in7_warning, ext_fault_in8_warning;
  logic [7:0]  ext_w;   // external warnings, terminal 1 at bit 0
  logic [3:0]  errs;    // range, input, curve, pid
  logic [31:0] rd_q;
  logic        err_q;
  int          n_fail = 0;
  int          tests_run = 0;
  int          i;
  // address, data, expected setting errors
  logic [43:0] cfg [26] = '{44'h00_00000005_8, 44'h00_00000033_8, 44'h00_00000023_0,
    44'h04_000001f4_8, 44'h04_00000064_0, 44'h08_00000032_8, 44'h08_000000c8_0,
    44'h10_000b0000_8, 44'h10_00000000_0, 44'h14_ffff0101_4, 44'h14_ffffff08_4,
    44'h14_ffff0908_0, 44'h14_ff0b0908_4, 44'h14_ffff2213_4, 44'h14_ffff3130_4,
    44'h14_ffffffff_0, 44'h1c_17701388_2, 44'h1c_13881770_0, 44'h20_00961388_2,
    44'h20_00960bb8_0, 44'h28_0bb80bb8_2, 44'h28_00960bb8_0, 44'h2c_00000011_1,
    44'h2c_00000022_1, 44'h2c_00000021_0, 44'h2c_00000000_0};
  logic [15:0] lv [5] = '{16'h0063, 16'h0064, 16'h00c8, 16'h012c, 16'h0000};
  logic [2:0]  oc [5] = '{3'h0, 3'h1, 3'h3, 3'h7, 3'h0};
  assign ext_w = {ext_fault_in8_warning, ext_fault_in7_warning, ext_fault_in6_warning,
    ext_fault_in5_warning, ext_fault_in4_warning, ext_fault_in3_warning,
    ext_fault_in2_warning, ext_fault_in1_warning};
  assign errs = {range_setting_error, input_assign_error, vf_curve_error, pid_source_error};
  dwm_monitor #(.TICK_CYCLES(10)) DUT (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr, .modbus_msg_rx, .current_level,
    .auto_reset_active, .term_in, .fwd_run_in, .rev_run_in, .comm_loss_warning,
    .overcurrent_level_a_warning, .overcurrent_level_b_warning, .current_feedback_warning,
    .retry_warning, .ext_fault_in1_warning, .ext_fault_in2_warning, .ext_fault_in3_warning,
    .ext_fault_in4_warning, .ext_fault_in5_warning, .ext_fault_in6_warning,
    .ext_fault_in7_warning, .ext_fault_in8_warning, .direction_conflict_warning,
    .stop_request, .range_setting_error, .input_assign_error, .vf_curve_error,
    .pid_source_error, .warning_blink(), .irq);
  dwm_host_model u_host (.pclk, .presetn, .period, .modbus_msg_rx);
  // 100 MHz clock
  initial
    forever #5 pclk = ~pclk;
  task automatic conclude();
    if (n_fail == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic gap(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge pclk);
    penable <= 1'b1;
    @(negedge pclk);
    while (pready !== 1'b1)
      @(negedge pclk);
    rd_q = prdata;
    err_q = pslverr;
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
    apb(a, 1'b0, 32'h0);
    `CHK("read data", x, rd_q)
    `CHK("slave error", xe, err_q)
  endtask
  // hang guard
  initial
  begin
    gap(60000);
    n_fail++;
    conclude();
  end
  initial
  begin
    gap(10);
    presetn <= 1'b1;
    @(posedge pclk);
    // reset values, unmapped and read-only places
    rd(`DWM_OFS_THR_A, `DWM_RST_THR, 1'b0);
    rd(`DWM_OFS_FUNC_LO, `DWM_RST_FUNC, 1'b0);
    rd(`DWM_OFS_VF1_HI, `DWM_RST_VF_HI, 1'b0);
    rd(8'h3c, 32'h0, 1'b1);
    rd(8'h02, 32'h0, 1'b1);
    wr(`DWM_OFS_WARN, 32'hffffffff);
    rd(`DWM_OFS_WARN, 32'h0, 1'b0);
    // current thresholds, boundary values included
    wr(`DWM_OFS_THR_A, 32'h64);
    wr(`DWM_OFS_THR_B, 32'hc8);
    wr(`DWM_OFS_THR_FB, 32'h12c);
    foreach (lv[k])
    begin
      current_level <= lv[k];
      gap(3);
      `CHK("current warnings", oc[k], {current_feedback_warning, overcurrent_level_b_warning,
           overcurrent_level_a_warning})
    end
    // sticky status, mask, clear by writing one
    rd(`DWM_OFS_INT_STAT, 32'he, 1'b0);
    `CHK("irq masked", 1'b0, irq)
    wr(`DWM_OFS_INT_MASK, 32'h2);
    gap(2);
    `CHK("irq", 1'b1, irq)
    wr(`DWM_OFS_INT_STAT, 32'he);
    gap(2);
    `CHK("irq cleared", 1'b0, irq)
    rd(`DWM_OFS_INT_STAT, 32'h0, 1'b0);
    // setting consistency
    foreach (cfg[k])
    begin
      wr(cfg[k][43:36], cfg[k][35:4]);
      gap(3);
      `CHK("setting errors", cfg[k][3:0], errs)
    end
    // external faults on every terminal
    wr(`DWM_OFS_FUNC_LO, 32'h19191919);
    wr(`DWM_OFS_FUNC_HI, 32'h19191919);
    for (i = 0; i < 8; i++)
    begin
      term_in <= 8'h01 << i;
      gap(4);
      `CHK("external warnings", 8'h01 << i, ext_w)
    end
    `CHK("input error", 1'b0, input_assign_error)
    wr(`DWM_OFS_CTRL, 32'h13);
    term_in <= 8'hff;
    gap(4);
    `CHK("external other response", 8'h00, ext_w)
    term_in <= 8'h00;
    wr(`DWM_OFS_CTRL, 32'h23);
    wr(`DWM_OFS_FUNC_LO, 32'hffffffff);
    wr(`DWM_OFS_FUNC_HI, 32'hffffffff);
    // retry needs a setting above zero, then lasts the delay
    auto_reset_active <= 1'b1;
    gap(5);
    `CHK("retry unset", 1'b0, retry_warning)
    auto_reset_active <= 1'b0;
    wr(`DWM_OFS_RETRY, 32'h5);
    auto_reset_active <= 1'b1;
    gap(5);
    `CHK("retry", 1'b1, retry_warning)
    gap(90);
    `CHK("retry expired", 1'b0, retry_warning)
    auto_reset_active <= 1'b0;
    // run commands close together, then far apart
    fwd_run_in <= 1'b1;
    gap(10);
    rev_run_in <= 1'b1;
    gap(5);
    `CHK("direction", 1'b1, direction_conflict_warning)
    `CHK("stop", 1'b1, stop_request)
    rev_run_in <= 1'b0;
    fwd_run_in <= 1'b0;
    gap(5);
    `CHK("direction cleared", 1'b0, direction_conflict_warning)
    fwd_run_in <= 1'b1;
    gap(5200);
    rev_run_in <= 1'b1;
    gap(5);
    `CHK("direction late", 1'b0, direction_conflict_warning)
    fwd_run_in <= 1'b0;
    rev_run_in <= 1'b0;
    // host traffic stops, then resumes
    `CHK("comm alive", 1'b0, comm_loss_warning)
    period <= 16'h0000;
    i = 0;
    while (comm_loss_warning !== 1'b1 && i < 25000)
    begin
      i++;
      @(posedge pclk);
    end
    `CHK("comm lost", 1'b1, comm_loss_warning)
    `CHK("silent span", 1'b1, i > 18000)
    period <= 16'h0032;
    gap(60);
    `CHK("comm back", 1'b0, comm_loss_warning)
    conclude();
  end
endmodule
